// ---- rtl/pic_top.sv ----
// Priority interrupt controller with the CPU's acceptance sequencer.
// Assumes request pulses from on-chip logic on clk_sys, pins asynchronous,
// and a CPU core that performs stacking and jumps on the strobes given here.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module pic_top
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request sources
  input wire logic nmi_pin,
  input wire logic [NUM_PINS-1:0] external_pin_request,
  input wire logic watchdog_request,
  input wire logic [NUM_MSK-1:0] source_request,
  // CPU instruction strobes
  input wire logic set_mask_instruction,
  input wire logic [2:0] set_mask_operand,
  input wire logic mask_all_instruction,
  input wire logic software_trap,
  input wire logic [2:0] software_trap_num,
  input wire logic illegal_op_trap,
  input wire logic first_insn_done,
  input wire logic return_from_handler,
  input wire logic [23:0] pop_pc,
  input wire logic [15:0] pop_status,
  // CPU context
  input wire logic [23:0] cpu_pc,
  input wire logic [15:0] cpu_status,
  input wire logic [23:0] system_stack_pointer,
  // Acceptance outputs
  output logic stack_push,
  output logic [23:0] stack_addr,
  output logic [23:0] push_pc,
  output logic [15:0] push_status,
  output logic handler_start,
  output logic [23:0] vector_fetch_addr,
  output logic resume_valid,
  output logic [23:0] resume_pc,
  output logic [15:0] resume_status,
  output logic busy,
  // Controller view
  output logic [2:0] cpu_mask_level,
  output logic [7:0] nesting_depth_counter,
  output logic [2:0] request_level,
  output logic request_valid,
  output logic [7:0] dma_start_code
);

  pic_state_t state;
  logic [31:0] level_reg [NUM_LEVEL_REGS];
  logic [3*NUM_MSK-1:0] levels;
  logic [NUM_MSK-1:0] pend;
  logic [NUM_MSK-1:0] pin_edge;
  logic [NUM_MSK-1:0] clr_src;
  logic nmi_pend;
  logic wd_pend;
  logic [NUM_PINS:0] sync1, sync2, sync3;
  logic arb_valid;
  logic [IDX_W-1:0] arb_idx;
  logic [2:0] arb_level;
  logic cand_valid;
  logic [2:0] cand_level;
  logic [7:0] cand_vec;
  logic [2:0] eff_mask;
  logic take_irq;
  logic take_trap;
  logic [7:0] trap_vec;
  logic [7:0] acc_vec;
  logic [2:0] acc_level;
  logic [IDX_W-1:0] acc_idx;
  logic acc_nmi, acc_wd, acc_trap;
  logic [4:0] cnt;
  logic acc_first;
  logic [2:0] next_mask;

  // Pins are asynchronous: two flops before the edge detector
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {nmi_pin, external_pin_request};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Per-source pending flip-flops; a new request wins over the clear
  for (genvar i = 0; i < NUM_MSK; i++) begin : g_src
    if (i >= IDX_RSVD_FIRST && i <= IDX_RSVD_LAST) begin : g_rsvd
      assign pin_edge[i] = 1'b0;
      assign levels[3*i +: 3] = 3'h0;
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          pend[i] <= 1'b0;
        end else begin
          pend[i] <= 1'b0;
        end
      end
    end else begin : g_live
      if (i >= IDX_PIN_FIRST && i < IDX_PIN_FIRST + NUM_PINS) begin : g_pin
        assign pin_edge[i] = sync2[i - IDX_PIN_FIRST] & ~sync3[i - IDX_PIN_FIRST];
      end else begin : g_int
        assign pin_edge[i] = 1'b0;
      end
      assign levels[3*i +: 3] =
        level_reg[i / LEVELS_PER_REG][(i % LEVELS_PER_REG) * LEVEL_FIELD_W +: 3];
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          pend[i] <= 1'b0;
        end else if (source_request[i] || pin_edge[i]) begin
          pend[i] <= 1'b1;
        end else if (clr_src[i]) begin
          pend[i] <= 1'b0;
        end
      end
    end
  end

  // Non-maskable pending flags, fixed at the top level
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nmi_pend <= 1'b0;
      wd_pend <= 1'b0;
    end else begin
      if (sync2[NUM_PINS] && !sync3[NUM_PINS]) begin
        nmi_pend <= 1'b1;
      end else if (state == PIC_VREAD && acc_nmi) begin
        nmi_pend <= 1'b0;
      end
      if (watchdog_request) begin
        wd_pend <= 1'b1;
      end else if (state == PIC_VREAD && acc_wd) begin
        wd_pend <= 1'b0;
      end
    end
  end

  pic_arbiter #(
    .N(NUM_MSK)
  ) u_arb (
    .pend(pend),
    .levels(levels),
    .win_valid(arb_valid),
    .win_idx(arb_idx),
    .win_level(arb_level)
  );

  // Candidate: NMI, then watchdog (smaller vectors), then maskable winner
  always_comb begin
    cand_valid = nmi_pend | wd_pend | arb_valid;
    if (nmi_pend) begin
      cand_level = LEVEL_TOP;
      cand_vec = VEC_NMI;
    end else if (wd_pend) begin
      cand_level = LEVEL_TOP;
      cand_vec = VEC_WATCHDOG;
    end else begin
      cand_level = arb_level;
      cand_vec = VEC_FIRST_MSK + {arb_idx, 2'b00};
    end
  end

  // A set-mask or mask-all instruction counts in the cycle it starts
  always_comb begin
    if (mask_all_instruction) begin
      eff_mask = LEVEL_TOP;
    end else if (set_mask_instruction) begin
      eff_mask = (set_mask_operand == 3'h0) ? LEVEL_MIN : set_mask_operand;
    end else begin
      eff_mask = cpu_mask_level;
    end
  end

  // Trap vectors: trap n at 4n, so trap two and the illegal trap coincide
  assign trap_vec = illegal_op_trap ? VEC_ILLEGAL : {3'h0, software_trap_num, 2'b00};
  assign take_trap = (state == PIC_IDLE) && (software_trap || illegal_op_trap);
  // Sampling only in idle: blocks new requests until first handler instruction
  assign take_irq = (state == PIC_IDLE) && !take_trap && cand_valid
                    && (cand_level >= eff_mask);

  always_comb begin
    clr_src = '0;
    if (state == PIC_VREAD && !acc_nmi && !acc_wd) begin
      clr_src[acc_idx] = 1'b1;
    end
  end

  // Acceptance sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= PIC_IDLE;
      cnt <= 5'h00;
      acc_first <= 1'b0;
    end else begin
      case (state)
        PIC_IDLE: begin
          if (take_trap) begin
            state <= PIC_ACCEPT;
            cnt <= ACCEPT_CNT_TRAP;
            acc_first <= 1'b1;
          end else if (take_irq) begin
            state <= PIC_VREAD;
          end
        end
        PIC_VREAD: begin
          state <= PIC_ACCEPT;
          cnt <= ACCEPT_CNT_IRQ;
          acc_first <= 1'b1;
        end
        PIC_ACCEPT: begin
          acc_first <= 1'b0;
          if (cnt == 5'h01) begin
            state <= PIC_FIRST;
          end
          cnt <= cnt - 5'h01;
        end
        PIC_FIRST: begin
          if (first_insn_done) begin
            state <= PIC_IDLE;
          end
        end
        default: begin
          state <= PIC_IDLE;
        end
      endcase
    end
  end

  // Latch what is being accepted; an interrupt's vector registers at the read cycle, a trap's at sampling
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_vec <= 8'h00;
      acc_level <= 3'h0;
      acc_idx <= '0;
      acc_nmi <= 1'b0;
      acc_wd <= 1'b0;
      acc_trap <= 1'b0;
    end else if (take_trap) begin
      acc_vec <= trap_vec;
      acc_trap <= 1'b1;
      acc_nmi <= 1'b0;
      acc_wd <= 1'b0;
    end else if (take_irq) begin
      acc_level <= cand_level;
      acc_idx <= arb_idx;
      acc_nmi <= nmi_pend;
      acc_wd <= wd_pend & ~nmi_pend;
      acc_trap <= 1'b0;
    end else if (state == PIC_VREAD) begin
      acc_vec <= acc_nmi ? VEC_NMI : acc_wd ? VEC_WATCHDOG
        : VEC_FIRST_MSK + {acc_idx, 2'b00};
    end
  end

  // New mask: top for NMI, else one above the accepted level, capped at the top
  always_comb begin
    if (acc_nmi) begin
      next_mask = LEVEL_TOP;
    end else begin
      next_mask = (acc_level == LEVEL_TOP) ? LEVEL_TOP : acc_level + 3'h1;
    end
  end

  // Mask field; a return restores it from the popped status word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpu_mask_level <= MASK_RESET;
    end else if (return_from_handler) begin
      cpu_mask_level <= pop_status[SW_MASK_LSB +: 3];
    end else if (state == PIC_ACCEPT && acc_first && !acc_trap) begin
      cpu_mask_level <= next_mask;
    end else if (mask_all_instruction) begin
      cpu_mask_level <= LEVEL_TOP;
    end else if (set_mask_instruction) begin
      cpu_mask_level <= (set_mask_operand == 3'h0) ? LEVEL_MIN : set_mask_operand;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nesting_depth_counter <= 8'h00;
    end else if (state == PIC_ACCEPT && acc_first) begin
      nesting_depth_counter <= nesting_depth_counter + 8'h01;
    end else if (return_from_handler) begin
      nesting_depth_counter <= nesting_depth_counter - 8'h01;
    end
  end

  // Stacking strobe carries the old mask inside the status word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stack_push <= 1'b0;
      stack_addr <= 24'h000000;
      push_pc <= 24'h000000;
      push_status <= 16'h0000;
    end else begin
      stack_push <= (state == PIC_ACCEPT) && acc_first;
      if (state == PIC_ACCEPT && acc_first) begin
        stack_addr <= system_stack_pointer - STACK_FRAME_BYTES;
        push_pc <= cpu_pc;
        push_status <= cpu_status;
        push_status[SW_MASK_LSB +: 3] <= cpu_mask_level;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      handler_start <= 1'b0;
      vector_fetch_addr <= 24'h000000;
    end else begin
      handler_start <= (state == PIC_ACCEPT) && (cnt == 5'h01);
      if (state == PIC_ACCEPT && cnt == 5'h01) begin
        vector_fetch_addr <= VEC_BASE | {16'h0000, acc_vec};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resume_valid <= 1'b0;
      resume_pc <= 24'h000000;
      resume_status <= 16'h0000;
    end else begin
      resume_valid <= return_from_handler;
      if (return_from_handler) begin
        resume_pc <= pop_pc;
        resume_status <= pop_status;
      end
    end
  end

  // Presented request and its DMA start code
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      request_valid <= 1'b0;
      request_level <= 3'h0;
      dma_start_code <= 8'h00;
    end else begin
      request_valid <= cand_valid;
      request_level <= cand_valid ? cand_level : 3'h0;
      if (!nmi_pend && !wd_pend && arb_valid
          && !(arb_idx >= IDX_W'(IDX_DMA_DONE_FIRST) && arb_idx <= IDX_W'(IDX_DMA_DONE_LAST))) begin
        dma_start_code <= {2'b00, cand_vec[7:2]};
      end else begin
        dma_start_code <= 8'h00;
      end
    end
  end

  assign busy = (state != PIC_IDLE);

  // APB slave: always ready, error on unmapped offsets
  logic rd_hit;
  logic [31:0] rd_mux;
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      REG_STATUS: begin
        rd_mux[ST_MASK_LSB +: 3] = cpu_mask_level;
        rd_mux[ST_NEST_LSB +: 8] = nesting_depth_counter;
        rd_mux[ST_CLVL_LSB +: 3] = cand_level;
        rd_mux[ST_CVAL_BIT] = cand_valid;
        rd_mux[ST_STATE_LSB +: 4] = state;
      end
      REG_PEND0: rd_mux = pend[31:0];
      REG_PEND1: rd_mux = {27'h0, nmi_pend, wd_pend, pend[NUM_MSK-1:32]};
      default: begin
        rd_hit = 1'b0;
        for (int r = 0; r < NUM_LEVEL_REGS; r++) begin
          if (paddr == REG_LEVEL0 + 12'(4 * r)) begin
            rd_hit = 1'b1;
            rd_mux = level_reg[r];
          end
        end
      end
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rd_hit;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Level fields are 3 bits in 4-bit slots; the spare bit reads zero
  for (genvar r = 0; r < NUM_LEVEL_REGS; r++) begin : g_lvl
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        level_reg[r] <= LEVEL_RESET;
      end else if (psel && penable && pwrite && paddr == REG_LEVEL0 + 12'(4 * r)) begin
        for (int b = 0; b < 4; b++) begin
          if (pstrb[b]) begin
            level_reg[r][8*b +: 8] <= pwdata[8*b +: 8] & 8'h77;
          end
        end
      end
    end
  end

endmodule : pic_top
`default_nettype wire

// ---- rtl/pic_pkg.sv ----
// Constants, register map and state encoding of the priority interrupt controller.
// Assumes a 32-bit APB register bus and one system clock.
package pic_pkg;

  // Sources and vectors
  localparam int NUM_MSK = 35;
  localparam int IDX_W = 6;
  localparam logic [23:0] VEC_BASE = 24'hFFFF00;
  localparam logic [7:0] VEC_FIRST_MSK = 8'h28;
  localparam logic [7:0] VEC_NMI = 8'h20;
  localparam logic [7:0] VEC_WATCHDOG = 8'h24;
  localparam logic [7:0] VEC_ILLEGAL = 8'h08;
  localparam int IDX_PIN_FIRST = 0;
  localparam int NUM_PINS = 4;
  localparam int IDX_DMA_DONE_FIRST = 24;
  localparam int IDX_DMA_DONE_LAST = 27;
  localparam int IDX_RSVD_FIRST = 28;
  localparam int IDX_RSVD_LAST = 30;

  // Levels and mask
  localparam logic [2:0] LEVEL_TOP = 3'h7;
  localparam logic [2:0] LEVEL_MIN = 3'h1;
  localparam logic [2:0] LEVEL_MAX_MSK = 3'h6;
  localparam logic [2:0] MASK_RESET = 3'h7;
  localparam int SW_MASK_LSB = 12;

  // Acceptance timing, one state per clock
  localparam int ACCEPT_STATES = 18;
  localparam logic [4:0] ACCEPT_CNT_IRQ = 5'(ACCEPT_STATES - 2);
  localparam logic [4:0] ACCEPT_CNT_TRAP = 5'(ACCEPT_STATES - 1);
  localparam logic [23:0] STACK_FRAME_BYTES = 24'h000006;

  // Register map
  localparam int NUM_LEVEL_REGS = 5;
  localparam int LEVEL_FIELD_W = 4;
  localparam int LEVELS_PER_REG = 8;
  localparam logic [11:0] REG_LEVEL0 = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h014;
  localparam logic [11:0] REG_PEND0 = 12'h018;
  localparam logic [11:0] REG_PEND1 = 12'h01C;
  localparam logic [31:0] LEVEL_RESET = 32'h00000000;
  localparam int ST_MASK_LSB = 0;
  localparam int ST_NEST_LSB = 8;
  localparam int ST_CLVL_LSB = 16;
  localparam int ST_CVAL_BIT = 19;
  localparam int ST_STATE_LSB = 20;

  typedef enum logic [3:0] {
    PIC_IDLE = 4'b0001,
    PIC_VREAD = 4'b0010,
    PIC_ACCEPT = 4'b0100,
    PIC_FIRST = 4'b1000
  } pic_state_t;

endpackage : pic_pkg

// ---- rtl/pic_arbiter.sv ----
// Highest-level, lowest-index selection among pending maskable sources.
// Assumes levels packed three bits per source, purely combinational.
`timescale 1ns/100ps
`default_nettype none
module pic_arbiter
  import pic_pkg::*;
#(
  parameter int N = NUM_MSK
) (
  // Requests and levels
  input wire logic [N-1:0] pend,
  input wire logic [3*N-1:0] levels,
  // Winner
  output logic win_valid,
  output logic [IDX_W-1:0] win_idx,
  output logic [2:0] win_level
);

  always_comb begin
    logic [2:0] lvl;
    lvl = 3'h0;
    win_valid = 1'b0;
    win_idx = '0;
    win_level = 3'h0;
    // Walk downward with >= so that the smaller vector wins a tie
    for (int i = N - 1; i >= 0; i--) begin
      lvl = levels[3*i +: 3];
      if (pend[i] && lvl >= LEVEL_MIN && lvl <= LEVEL_MAX_MSK && lvl >= win_level) begin
        win_valid = 1'b1;
        win_idx = IDX_W'(i);
        win_level = lvl;
      end
    end
  end

endmodule : pic_arbiter
`default_nettype wire

// ---- rtl/dummy_unused_guard.sv ----
`timescale 1ns/100ps

// ---- verif/pic_properties.sv ----
// Port-level checker for the priority interrupt controller.
// Assumes binding into pic_top, one clock domain, async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module pic_properties
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // CPU strobes
  input wire logic set_mask_instruction,
  input wire logic [2:0] set_mask_operand,
  input wire logic mask_all_instruction,
  input wire logic return_from_handler,
  input wire logic [15:0] pop_status,
  input wire logic [23:0] system_stack_pointer,
  // Acceptance outputs
  input wire logic stack_push,
  input wire logic [23:0] stack_addr,
  input wire logic handler_start,
  input wire logic [23:0] vector_fetch_addr,
  input wire logic resume_valid,
  input wire logic busy,
  input wire logic [2:0] cpu_mask_level,
  input wire logic [7:0] nesting_depth_counter,
  input wire logic [2:0] request_level,
  input wire logic request_valid
);
  logic [2:0] pop_mask;
  assign pop_mask = pop_status[14:12];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence handler_go;
    ##[15:17] handler_start;
  endsequence
  sequence unwound;
    ##1 resume_valid && nesting_depth_counter == $past(nesting_depth_counter) - 8'h01;
  endsequence
  mask_reset_a:
    assert property ($rose(rstn) |-> cpu_mask_level == MASK_RESET) else $error("mask not set");
  mask_all_a:
    assert property (mask_all_instruction && !return_from_handler && !busy
      |=> cpu_mask_level == LEVEL_TOP) else $error("mask-all failed");
  set_mask_a:
    assert property (set_mask_instruction && !mask_all_instruction && !return_from_handler
      && !busy |=> cpu_mask_level == (($past(set_mask_operand) == 3'h0) ? LEVEL_MIN
      : $past(set_mask_operand))) else $error("set-mask failed");
  stack_frame_a:
    assert property ($rose(stack_push) |-> stack_addr == $past(system_stack_pointer)
      - STACK_FRAME_BYTES) else $error("bad stack address");
  nest_up_a:
    assert property ($rose(stack_push) |-> nesting_depth_counter
      == $past(nesting_depth_counter) + 8'h01) else $error("nesting not raised");
  accept_time_a:
    assert property ($rose(stack_push) |-> handler_go) else $error("handler late");
  nest_down_a:
    assert property (return_from_handler |-> unwound) else $error("return not unwound");
  mask_back_a:
    assert property (return_from_handler |=> cpu_mask_level == $past(pop_mask))
      else $error("mask not restored");
  vec_area_a:
    assert property (handler_start |-> vector_fetch_addr[23:8] == VEC_BASE[23:8]
      && vector_fetch_addr[1:0] == 2'b00) else $error("vector outside table");
  level_zero_a:
    assert property (request_valid |-> request_level != 3'h0) else $error("level zero shown");
  first_hold_a:
    assert property ($rose(handler_start) |-> busy) else $error("busy dropped early");
endmodule : pic_properties
bind pic_top pic_properties chk (.clk_sys, .rstn, .set_mask_instruction,
  .set_mask_operand, .mask_all_instruction, .return_from_handler, .pop_status,
  .system_stack_pointer, .stack_push, .stack_addr, .handler_start, .vector_fetch_addr,
  .resume_valid, .busy, .cpu_mask_level, .nesting_depth_counter, .request_level,
  .request_valid);
`default_nettype wire

// ---- verif/pic_cpu_model.sv ----
// Behavioural CPU core facing the controller: stack, return, first instruction.
// Assumes the bench asks for a return only while the controller is not busy.
`timescale 1ns/100ps
`default_nettype none
module pic_cpu_model
  import pic_pkg::*;
#(
  parameter logic [23:0] SP_INIT = 24'h000800
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // From the controller
  input wire logic stack_push,
  input wire logic [23:0] push_pc,
  input wire logic [15:0] push_status,
  input wire logic handler_start,
  input wire logic [2:0] cpu_mask_level,
  // Bench command
  input wire logic ret_req,
  // To the controller
  output logic first_insn_done,
  output logic return_from_handler,
  output logic [23:0] pop_pc,
  output logic [15:0] pop_status,
  output logic [23:0] cpu_pc,
  output logic [15:0] cpu_status,
  output logic [23:0] system_stack_pointer
);
  logic [39:0] frames [0:15];
  logic [3:0] depth;
  logic [1:0] first_cnt;
  assign cpu_status = {1'b0, cpu_mask_level, 12'h0A5};
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      depth <= 4'h0;
      system_stack_pointer <= SP_INIT;
      cpu_pc <= 24'h001000;
      return_from_handler <= 1'b0;
      pop_pc <= 24'h0;
      pop_status <= 16'h0;
    end else begin
      cpu_pc <= cpu_pc + 24'h000002;
      return_from_handler <= 1'b0;
      // Stale frame lines outside a return expose a late sample
      pop_pc <= ~pop_pc;
      pop_status <= ~pop_status;
      if (stack_push) begin
        frames[depth] <= {push_pc, push_status};
        depth <= depth + 4'h1;
        system_stack_pointer <= system_stack_pointer - STACK_FRAME_BYTES;
      end else if (ret_req && depth != 4'h0) begin
        {pop_pc, pop_status} <= frames[depth - 4'h1];
        depth <= depth - 4'h1;
        system_stack_pointer <= system_stack_pointer + STACK_FRAME_BYTES;
        return_from_handler <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      first_cnt <= 2'h0;
      first_insn_done <= 1'b0;
    end else begin
      first_insn_done <= (first_cnt == 2'h1);
      if (handler_start) begin
        first_cnt <= 2'h3;
      end else if (first_cnt != 2'h0) begin
        first_cnt <= first_cnt - 2'h1;
      end
    end
  end
endmodule : pic_cpu_model
`default_nettype wire

// ---- verif/priority_interrupt_controller_tb.sv ----
// Self-checking bench for pic_top with a behavioural CPU model.
// Assumes APB answers on its own pready and a 125 MHz system clock.
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_controller_tb;
  import pic_pkg::*;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, rerr, busy;
  logic nmi_pin, watchdog_request, set_mask_instruction, mask_all_instruction;
  logic software_trap, illegal_op_trap, first_insn_done, return_from_handler, ret_req;
  logic stack_push, handler_start, request_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_MSK-1:0] source_request;
  logic [2:0] set_mask_operand, software_trap_num, lvl, cpu_mask_level, request_level;
  logic [23:0] pop_pc, cpu_pc, system_stack_pointer, stack_addr, push_pc, vector_fetch_addr;
  logic [15:0] pop_status, cpu_status, push_status;
  logic [7:0] nesting_depth_counter, dma_start_code;
  logic [2:0] lv [0:NUM_MSK-1];
  int err_total, n_compared, i1, i2;
  integer seed;
  pic_top uut (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .nmi_pin, .external_pin_request(4'h0), .watchdog_request,
    .source_request, .set_mask_instruction, .set_mask_operand, .mask_all_instruction,
    .software_trap, .software_trap_num, .illegal_op_trap, .first_insn_done,
    .return_from_handler, .pop_pc, .pop_status, .cpu_pc, .cpu_status, .system_stack_pointer,
    .stack_push, .stack_addr, .push_pc, .push_status, .handler_start, .vector_fetch_addr,
    .resume_valid(), .resume_pc(), .resume_status(), .busy, .cpu_mask_level,
    .nesting_depth_counter, .request_level, .request_valid, .dma_start_code);
  pic_cpu_model cpu (.clk_sys, .rstn, .stack_push, .push_pc, .push_status, .handler_start,
    .cpu_mask_level, .ret_req, .first_insn_done, .return_from_handler, .pop_pc,
    .pop_status, .cpu_pc, .cpu_status, .system_stack_pointer);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic timeout;
    err_total++;
    final_report();
  endtask : timeout
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) timeout();
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  function automatic logic [31:0] lword(input int w);
    lword = 32'h0;
    for (int j = 0; j < LEVELS_PER_REG; j++)
      if (w * 8 + j < NUM_MSK) lword[j * 4 +: 3] = lv[w * 8 + j];
  endfunction : lword
  function automatic logic [23:0] vaddr(input int i);
    return VEC_BASE | 24'(int'(VEC_FIRST_MSK) + 4 * i);
  endfunction : vaddr
  function automatic logic [7:0] dcode(input int i);
    if (i >= IDX_DMA_DONE_FIRST && i <= IDX_DMA_DONE_LAST) return 8'h00;
    return 8'((int'(VEC_FIRST_MSK) + 4 * i) / 4);
  endfunction : dcode
  function automatic logic [7:0] evec(input int k);
    if (k < 8) return 8'(4 * k);
    return k == 8 ? VEC_ILLEGAL : (k == 9 ? VEC_NMI : VEC_WATCHDOG);
  endfunction : evec
  task automatic set_levels;
    for (int w = 0; w < NUM_LEVEL_REGS; w++) begin
      apb(1'b1, 12'(4 * w), lword(w));
      apb(1'b0, 12'(4 * w), 32'h0);
      check(rd, lword(w));
    end
  endtask : set_levels
  task automatic wait_hs;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (handler_start !== 1'b1 && k < 40);
    if (k == 40) timeout();
  endtask : wait_hs
  task automatic finish_handler(input logic [7:0] nest);
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 40) begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 40) timeout();
    repeat (3) @(posedge clk_sys);
    check(32'(nesting_depth_counter), 32'(nest));
    ret_req <= 1'b1;
    @(posedge clk_sys);
    ret_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : finish_handler
  initial begin
    seed = 32'hB79C;
    {rstn, psel, penable, pwrite, nmi_pin, watchdog_request, ret_req} = 7'h0;
    {set_mask_instruction, mask_all_instruction, software_trap, illegal_op_trap} = 4'h0;
    {set_mask_operand, software_trap_num} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    source_request = '0;
    foreach (lv[i]) lv[i] = 3'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int w = 0; w < NUM_LEVEL_REGS; w++) begin
      apb(1'b0, 12'(4 * w), 32'h0);
      check(rd, LEVEL_RESET);
    end
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h00100007);
    apb(1'b0, 12'h020, 32'h0);
    check(32'(rerr), 32'h1);
    for (int n = 0; n < 6; n++) begin
      i1 = n == 0 ? 31 : $unsigned($random(seed)) % 14;
      i2 = n == 0 ? 34 : i1 + 1 + $unsigned($random(seed)) % 14;
      lvl = n == 1 ? 3'h6 : 3'(1 + $unsigned($random(seed)) % 6);
      lv[i1] = lvl;
      lv[i2] = lvl;
      set_levels();
      mask_all_instruction <= 1'b1;
      @(posedge clk_sys);
      mask_all_instruction <= 1'b0;
      source_request <= (NUM_MSK'(1) << i1) | (NUM_MSK'(1) << i2);
      @(posedge clk_sys);
      source_request <= '0;
      repeat (4) @(posedge clk_sys);
      check(32'(busy), 32'h0);
      check(32'(request_level), 32'(lvl));
      check(32'(dma_start_code), 32'(dcode(i1)));
      set_mask_operand <= n[0] ? 3'h0 : lvl;
      set_mask_instruction <= 1'b1;
      @(posedge clk_sys);
      set_mask_instruction <= 1'b0;
      wait_hs();
      check(32'(vector_fetch_addr), 32'(vaddr(i1)));
      check(32'(cpu_mask_level), 32'(lvl == 3'h6 ? 3'h7 : lvl + 3'h1));
      check(32'(nesting_depth_counter), 32'h1);
      finish_handler(8'h01);
      wait_hs();
      check(32'(vector_fetch_addr), 32'(vaddr(i2)));
      finish_handler(8'h01);
      check(32'(cpu_mask_level), 32'(n[0] ? 3'h1 : lvl));
    end
    for (int k = 0; k < 11; k++) begin
      software_trap <= k < 8;
      software_trap_num <= 3'(k);
      illegal_op_trap <= k == 8;
      nmi_pin <= k == 9;
      watchdog_request <= k == 10;
      @(posedge clk_sys);
      {software_trap, illegal_op_trap, watchdog_request} <= 3'h0;
      wait_hs();
      nmi_pin <= 1'b0;
      check(32'(vector_fetch_addr), 32'(VEC_BASE | 24'(evec(k))));
      check(32'(cpu_mask_level), 32'(k < 9 ? 3'h1 : 3'h7));
      finish_handler(8'h01);
    end
    lv[5] = 3'h0;
    lv[6] = 3'h7;
    set_levels();
    source_request <= NUM_MSK'(8'h60);
    @(posedge clk_sys);
    source_request <= '0;
    repeat (25) @(posedge clk_sys);
    check(32'(nesting_depth_counter), 32'h0);
    final_report();
  end
endmodule : priority_interrupt_controller_tb
`default_nettype wire
